// >>> bench/ahb_master_model.sv
// program-memory side: feeds words and register accesses over ahb-lite
`default_nettype none
module ahb_master_model (
	// clock and bus answer
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// bus request
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial
	begin
		hsel   = 1'b1;
		haddr  = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'b010;
		hwdata = 32'h0000_0000;
	end

	// one single word transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q);
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		// address phase stands until the slave is ready; only the watchdog ends a hang
		do
		begin
			@(posedge hclk);
		end while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do
		begin
			@(posedge hclk);
		end while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
endmodule : ahb_master_model
`default_nettype wire

// >>> bench/insn_exec_bench.sv
// self-checking bench for the instruction execution block
`default_nettype none
module insn_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic [1:0]  hresp;
	logic [3:0]  port0;
	logic [3:0]  port1;
	logic [1:0]  port2;
	logic [1:0]  port3;
	logic        key_port;
	logic        port_c;
	logic [5:0]  port_d;
	logic [1:0]  powerdown;
	int          num_errors;
	int          n_checks;

	insn_exec uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.port0(port0), .port1(port1), .port2(port2), .port3(port3),
		.key_port(key_port), .port_c(port_c), .port_d(port_d), .powerdown(powerdown)
	);

	ahb_master_model bus (
		.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata)
	);

	// clock
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus.xfer(1'b1, {24'h00_0000, a}, d, q);
	endtask : wr

	// execute one instruction word
	task automatic ex(input logic [9:0] op);
		wr(insn_exec_pkg::REG_INSN, {22'h00_0000, op});
	endtask : ex

	// read a register and compare the masked value; port reads also check the pins
	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		logic [31:0] p;
		bus.xfer(1'b0, {24'h00_0000, a}, 32'h0000_0000, q);
		p = q;
		if (a == insn_exec_pkg::REG_PORT)
			p = {10'h000, powerdown, port_d, port_c, key_port, port3, port2, port1, port0};
		n_checks++;
		if ((q & m) !== e || (p & m) !== e || hresp !== insn_exec_pkg::HRESP_OKAY)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t addr=%h got=%h pins=%h resp=%h exp=%h",
				$time, a, q & m, p & m, hresp, e);
		end
	endtask : chk

	task automatic done(input string s);
		$display("test %s finished, mismatches so far %0d", s, num_errors);
	endtask : done

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// watchdog, the whole sequence needs a few hundred cycles
	initial
	begin
		#300000;
		num_errors++;
		give_verdict();
	end

	// main sequence
	initial
	begin
		logic [3:0] ta[4];
		logic [3:0] tn[4];
		logic [31:0] ev;
		num_errors = 0;
		n_checks = 0;
		hresetn = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(insn_exec_pkg::REG_PORT, 32'h003F_FFFF, 32'h0000_0000);
		chk(insn_exec_pkg::REG_PCSP, 32'h0007_73FF, 32'h0000_7000);
		wr(8'h1C, 32'hFFFF_FFFF);
		chk(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
		done("reset");
		for (int z = 0; z < 4; z++)
		begin
			ex(insn_exec_pkg::OP_LZ | 10'(z));
			chk(insn_exec_pkg::REG_PTR, 32'h0000_0300, z << 8);
		end
		wr(insn_exec_pkg::REG_PCSP, 32'h0000_0005);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_01A5);
		ex(insn_exec_pkg::OP_NOP);
		chk(insn_exec_pkg::REG_PCSP, 32'h0000_03FF, 32'h0000_0006);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, 32'h0000_01A5);
		chk(insn_exec_pkg::REG_PORT, 32'h003F_FFFF, 32'h0000_0000);
		done("lz_nop");
		// two patterns so every bit of ports 0 to 3 and the key port sees both levels
		wr(insn_exec_pkg::REG_ACC, 32'h0000_000A);
		ex(insn_exec_pkg::OP_KEY);
		ex(insn_exec_pkg::OP_P0);
		ex(insn_exec_pkg::OP_P1);
		ex(insn_exec_pkg::OP_P2);
		ex(insn_exec_pkg::OP_P3);
		chk(insn_exec_pkg::REG_PORT, 32'h0000_1FFF, 32'h0000_0AAA);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_0005);
		ex(insn_exec_pkg::OP_KEY);
		ex(insn_exec_pkg::OP_P0);
		ex(insn_exec_pkg::OP_P1);
		ex(insn_exec_pkg::OP_P2);
		ex(insn_exec_pkg::OP_P3);
		chk(insn_exec_pkg::REG_PORT, 32'h0000_1FFF, 32'h0000_1555);
		done("ports");
		wr(insn_exec_pkg::REG_PTR, 32'h0000_0000);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_0105);
		wr(insn_exec_pkg::REG_MEM, 32'h0000_000A);
		ex(insn_exec_pkg::OP_OR);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_010F, 32'h0000_010F);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_0102);
		ex(insn_exec_pkg::OP_ROT);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_010F, 32'h0000_0009);
		ex(insn_exec_pkg::OP_ROT);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_010F, 32'h0000_0104);
		done("or_rotate");
		// set bits one by one, then clear them in the same order
		wr(insn_exec_pkg::REG_MEM, 32'h0000_0000);
		for (int j = 0; j < 4; j++)
		begin
			ex(insn_exec_pkg::OP_MB_SET | 10'(j));
			chk(insn_exec_pkg::REG_MEM, 32'h0000_000F, (1 << (j + 1)) - 1);
		end
		for (int j = 0; j < 4; j++)
		begin
			ex(insn_exec_pkg::OP_MB_CLR | 10'(j));
			chk(insn_exec_pkg::REG_MEM, 32'h0000_000F, (32'h0F << (j + 1)) & 32'h0F);
		end
		wr(insn_exec_pkg::REG_ACC, 32'h0000_0000);
		ex(insn_exec_pkg::OP_CY_SET);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, 32'h0000_0100);
		ex(insn_exec_pkg::OP_CY_CLR);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, 32'h0000_0000);
		ex(insn_exec_pkg::OP_PC_SET);
		chk(insn_exec_pkg::REG_PORT, 32'h0000_2000, 32'h0000_2000);
		ex(insn_exec_pkg::OP_PC_CLR);
		chk(insn_exec_pkg::REG_PORT, 32'h0000_2000, 32'h0000_0000);
		done("bits");
		// y of six and seven lies outside the port and must leave it alone
		for (int y = 0; y < 8; y++)
		begin
			wr(insn_exec_pkg::REG_PTR, y);
			ex(insn_exec_pkg::OP_PD_SET);
			ev = (y < 6 ? (1 << (y + 1)) - 1 : 32'h3F) << 14;
			chk(insn_exec_pkg::REG_PORT, 32'h000F_C000, ev);
		end
		for (int y = 0; y < 8; y++)
		begin
			wr(insn_exec_pkg::REG_PTR, y);
			ex(insn_exec_pkg::OP_PD_CLR);
			ev = (y < 6 ? (32'h3F << (y + 1)) & 32'h3F : 0) << 14;
			chk(insn_exec_pkg::REG_PORT, 32'h000F_C000, ev);
		end
		done("portd");
		ex(insn_exec_pkg::OP_PD_DET);
		chk(insn_exec_pkg::REG_PORT, 32'h0030_0000, 32'h0000_0000);
		ex(insn_exec_pkg::OP_PD_EN);
		ex(insn_exec_pkg::OP_PD_DET);
		chk(insn_exec_pkg::REG_PORT, 32'h0030_0000, 32'h0010_0000);
		wr(insn_exec_pkg::REG_PORT, 32'h0000_0000);
		ex(insn_exec_pkg::OP_PD_EN);
		ex(insn_exec_pkg::OP_NOP);
		ex(insn_exec_pkg::OP_PD_ALL);
		chk(insn_exec_pkg::REG_PORT, 32'h0030_0000, 32'h0000_0000);
		ex(insn_exec_pkg::OP_PD_EN);
		ex(insn_exec_pkg::OP_PD_ALL);
		chk(insn_exec_pkg::REG_PORT, 32'h0030_0000, 32'h0020_0000);
		wr(insn_exec_pkg::REG_PORT, 32'h0000_0000);
		chk(insn_exec_pkg::REG_PORT, 32'h0030_0000, 32'h0000_0000);
		done("powerdown");
		// carry set after the compare shows whether it was skipped
		ta = '{4'h3, 4'h3, 4'hF, 4'h0};
		tn = '{4'h3, 4'h4, 4'hF, 4'hF};
		for (int i = 0; i < 4; i++)
		begin
			wr(insn_exec_pkg::REG_ACC, {28'h000_0000, ta[i]});
			ex(insn_exec_pkg::OP_SEA1);
			ex(insn_exec_pkg::OP_SEA2 | tn[i]);
			ex(insn_exec_pkg::OP_CY_SET);
			chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, {23'h0, ta[i] != tn[i], 4'h0, ta[i]});
		end
		for (int i = 0; i < 2; i++)
		begin
			wr(insn_exec_pkg::REG_PTR, 32'h0000_0000);
			wr(insn_exec_pkg::REG_MEM, 32'h0000_0006 + i);
			wr(insn_exec_pkg::REG_ACC, 32'h0000_0006);
			ex(insn_exec_pkg::OP_SKIP_ACC_EQ_MEM);
			ex(insn_exec_pkg::OP_CY_SET);
			chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, {23'h0, i == 1, 8'h06});
		end
		done("compare");
		wr(insn_exec_pkg::REG_PCSP, 32'h0000_0010);
		wr(insn_exec_pkg::REG_CALL, 32'h0000_0100);
		chk(insn_exec_pkg::REG_PCSP, 32'h0000_73FF, 32'h0000_0100);
		ex(insn_exec_pkg::OP_RT);
		chk(insn_exec_pkg::REG_PCSP, 32'h0000_73FF, 32'h0000_7010);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_0000);
		wr(insn_exec_pkg::REG_CALL, 32'h0000_0100);
		ex(insn_exec_pkg::OP_RTS);
		ex(insn_exec_pkg::OP_CY_SET);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, 32'h0000_0000);
		chk(insn_exec_pkg::REG_PCSP, 32'h0000_73FF, 32'h0000_7011);
		// chain state set before entry and cleared after, so its restore is visible
		wr(insn_exec_pkg::REG_PCSP, 32'h0008_0020);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_01A5);
		wr(insn_exec_pkg::REG_PTR, 32'h0000_02B4);
		wr(insn_exec_pkg::REG_CALL, 32'h0001_0100);
		wr(insn_exec_pkg::REG_ACC, 32'h0000_0000);
		wr(insn_exec_pkg::REG_PTR, 32'h0000_0000);
		wr(insn_exec_pkg::REG_PCSP, 32'h0000_0100);
		chk(insn_exec_pkg::REG_PCSP, 32'h0008_0000, 32'h0000_0000);
		ex(insn_exec_pkg::OP_RTI);
		chk(insn_exec_pkg::REG_ACC, 32'h0000_01FF, 32'h0000_01A5);
		chk(insn_exec_pkg::REG_PTR, 32'h0000_03FF, 32'h0000_02B4);
		chk(insn_exec_pkg::REG_PCSP, 32'h000F_73FF, 32'h0008_7020);
		done("returns");
		give_verdict();
	end
endmodule : insn_exec_bench
`default_nettype wire

// >>> core/insn_exec.sv
// executor for a subset of a 4-bit core's instructions, fed over ahb-lite
// What this block does
// [RULE_01] load_bank_pointer copies the 2-bit immediate into bank pointer z in one cycle.
// [RULE_02] no_operation only advances the program counter by one and clears the powerdown prefix.
// [RULE_03] out_key_port_bit drives the key port latch with accumulator bit 0.
// [RULE_04] out_port0/1_from_acc write all four accumulator bits to the port latch.
// [RULE_05] out_port2_from_acc writes accumulator bits 1:0 to port 2.
// [RULE_06] out_port3_from_acc writes accumulator bits 1:0 to port 3.
// [RULE_07] or instruction: accumulator becomes accumulator or memory nibble; carry kept.
// [RULE_08] powerdown_detector_on enters retention, detector on, only right after the prefix.
// [RULE_09] powerdown_all_stopped enters retention, all stopped, only right after the prefix.
// [RULE_10] rotate_right_carry: old carry into bit 3, old bit 0 into carry.
// [RULE_11] mem_bit_set and mem_bit_clear force only the selected memory nibble bit.
// [RULE_12] portd set/clear force bit y of port d; y above five does nothing.
// [RULE_13] irq_return pops pc, decrements pointer, restores saved pointer, flags, a and b.
// [RULE_14] skip_acc_eq_imm: two words, skips next when accumulator equals immediate.
// [RULE_15] skip_acc_eq_mem skips next when accumulator equals the memory nibble.
// [RULE_16] sub_return pops pc over two cycles; skipping variant always skips next.
// [RULE_17] carry and port c clear/set force their bit in one cycle.
//
// The register addresses and the AHB-Lite register port were decided locally.
`default_nettype none
module insn_exec #(
	parameter int PC_W   = insn_exec_pkg::PC_W,
	parameter int RAM_AW = insn_exec_pkg::RAM_AW,
	parameter int DEPTH  = insn_exec_pkg::STACK_DEPTH
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	// port latches
	output logic      [3:0]  port0,
	output logic      [3:0]  port1,
	output logic      [1:0]  port2,
	output logic      [1:0]  port3,
	output logic             key_port,
	output logic             port_c,
	output logic      [5:0]  port_d,
	// power state
	output logic      [1:0]  powerdown
);
	localparam int RAM_N = 1 << RAM_AW;
	typedef logic [insn_exec_pkg::ENTRY_W-1:0] entry_t;

	stack_if #(.W(insn_exec_pkg::ENTRY_W), .SPW(insn_exec_pkg::SP_W)) stk ();

	return_stack #(.W(insn_exec_pkg::ENTRY_W), .DEPTH(DEPTH), .SPW(insn_exec_pkg::SP_W)) u_stack (
		.hclk    (hclk),
		.hresetn (hresetn),
		.s       (stk.store)
	);

	insn_exec_pkg::exec_state_t st, next_st;
	logic [3:0]  a, next_a, b, next_b, x, next_x, y, next_y;
	logic [1:0]  z, next_z;
	logic        cy, next_cy, skip, next_skip, chain, next_chain;
	logic        sea_wait, next_sea_wait, swallow, next_swallow, prefix, next_prefix;
	logic [PC_W-1:0] pc, next_pc;
	logic [9:0]  insn, next_insn;
	logic [3:0]  ram [RAM_N];
	logic [3:0]  next_ram [RAM_N];
	logic [3:0]  next_p0, next_p1;
	logic [1:0]  next_p2, next_p3, next_pd, next_hresp;
	logic        next_k, next_c;
	logic [5:0]  next_d;
	logic [31:0] next_hrdata;
	logic        next_ready;
	logic [7:0]  addr_q, next_addr_q;
	logic        wr_q, next_wr_q;
	logic [RAM_AW-1:0] dp_idx;
	logic [3:0]  mem_dp;
	logic        live;
	logic [9:0]  dp_cat;
	entry_t      top;

	// ram index from the data pointer; narrow ram sees the low bits
	assign dp_cat = {z, x, y};
	assign dp_idx = dp_cat[RAM_AW-1:0];
	assign mem_dp = ram[dp_idx];
	assign top    = stk.rdata;
	// an instruction that really runs: not skipped, not a second word, not powered down
	assign live   = (st == insn_exec_pkg::ST_EXEC) && (powerdown == insn_exec_pkg::PD_RUN)
		&& !skip && !sea_wait;

	// next state of bus slave, executor and latches
	always_comb
	begin
		next_st = st;       next_a = a;         next_b = b;         next_x = x;
		next_y = y;         next_z = z;         next_cy = cy;       next_skip = skip;
		next_chain = chain; next_sea_wait = sea_wait;               next_swallow = swallow;
		next_prefix = prefix;                   next_pc = pc;       next_insn = insn;
		next_ram = ram;     next_p0 = port0;    next_p1 = port1;    next_p2 = port2;
		next_p3 = port3;    next_k = key_port;  next_c = port_c;    next_d = port_d;
		next_pd = powerdown;                    next_hrdata = hrdata;
		next_addr_q = addr_q;                   next_wr_q = 1'b0;
		next_hresp = insn_exec_pkg::HRESP_OKAY;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		stk.wdata = '0;
		// address phase: only taken while idle, so hrdata is a snapshot of settled state
		if (hsel && htrans[1] && hready)
		begin
			next_addr_q = haddr[7:0];
			next_wr_q   = hwrite;
			next_hrdata = '0;
			unique case (haddr[7:0])
				insn_exec_pkg::REG_INSN: next_hrdata[9:0] = insn;
				insn_exec_pkg::REG_ACC:  next_hrdata[8:0] = {cy, b, a};
				insn_exec_pkg::REG_PTR:  next_hrdata[9:0] = {z, x, y};
				insn_exec_pkg::REG_PORT: next_hrdata[21:0] = {powerdown, port_d, port_c,
					key_port, port3, port2, port1, port0};
				insn_exec_pkg::REG_PCSP: next_hrdata = {12'h000, chain, prefix, sea_wait,
					skip, 1'b0, stk.sp, {(12-PC_W){1'b0}}, pc};
				insn_exec_pkg::REG_MEM:  next_hrdata[3:0] = mem_dp;
				default:                 next_hrdata = '0;
			endcase
		end
		// data phase of a write
		if (wr_q)
		begin
			unique case (addr_q)
				insn_exec_pkg::REG_INSN:
				begin
					next_insn = hwdata[9:0];
					next_st   = insn_exec_pkg::ST_EXEC;
				end
				insn_exec_pkg::REG_ACC:
				begin
					next_a  = hwdata[3:0];
					next_b  = hwdata[7:4];
					next_cy = hwdata[8];
				end
				insn_exec_pkg::REG_PTR:
				begin
					next_y = hwdata[3:0];
					next_x = hwdata[7:4];
					next_z = hwdata[9:8];
				end
				insn_exec_pkg::REG_PORT: next_pd = insn_exec_pkg::PD_RUN;
				insn_exec_pkg::REG_PCSP:
				begin
					next_pc    = hwdata[PC_W-1:0];
					next_chain = hwdata[insn_exec_pkg::CHAIN_BIT];
				end
				insn_exec_pkg::REG_MEM: next_ram[dp_idx] = hwdata[3:0];
				insn_exec_pkg::REG_CALL:
				begin
					// interrupt entry also saves the context for irq_return
					stk.push  = 1'b1;
					stk.wdata = {pc, 21'h00_0000};
					if (hwdata[insn_exec_pkg::IRQ_BIT])
						stk.wdata = {pc, x, y, z, cy, skip, chain, a, b};
					next_pc   = hwdata[PC_W-1:0];
					next_skip = 1'b0;
				end
				default: ;
			endcase
		end
		// execute
		unique case (st)
			insn_exec_pkg::ST_IDLE: ;
			insn_exec_pkg::ST_EXEC:
			begin
				next_st = insn_exec_pkg::ST_IDLE;
				if (powerdown == insn_exec_pkg::PD_RUN)
				begin
					next_pc = pc + 1'b1;
					next_prefix = 1'b0;
				end
				if (powerdown != insn_exec_pkg::PD_RUN)
					next_pc = pc;
				else if (sea_wait)
				begin
					next_sea_wait = 1'b0;
					next_swallow  = 1'b0;
					if (!swallow && a == insn[3:0])
						next_skip = 1'b1; // RULE_14
				end
				else if (skip)
				begin
					// a skipped two-word compare also eats its second word
					next_skip = 1'b0;
					if (insn == insn_exec_pkg::OP_SEA1)
					begin
						next_sea_wait = 1'b1;
						next_swallow  = 1'b1;
					end
				end
				else if (insn[9:2] == insn_exec_pkg::OP_LZ[9:2])
					next_z = insn[1:0]; // RULE_01
				else if (insn[9:2] == insn_exec_pkg::OP_MB_CLR[9:2])
					next_ram[dp_idx][insn[1:0]] = 1'b0; // RULE_11
				else if (insn[9:2] == insn_exec_pkg::OP_MB_SET[9:2])
					next_ram[dp_idx][insn[1:0]] = 1'b1; // RULE_11
				else
				begin
					case (insn)
						insn_exec_pkg::OP_NOP: ; // RULE_02
						insn_exec_pkg::OP_KEY: next_k = a[0]; // RULE_03
						insn_exec_pkg::OP_P0: next_p0 = a; // RULE_04
						insn_exec_pkg::OP_P1: next_p1 = a; // RULE_04
						insn_exec_pkg::OP_P2: next_p2 = a[1:0]; // RULE_05
						insn_exec_pkg::OP_P3: next_p3 = a[1:0]; // RULE_06
						insn_exec_pkg::OP_OR: next_a = a | mem_dp; // RULE_07
						insn_exec_pkg::OP_PD_EN: next_prefix = 1'b1;
						insn_exec_pkg::OP_PD_DET:
							if (prefix)
								next_pd = insn_exec_pkg::PD_DET; // RULE_08
						insn_exec_pkg::OP_PD_ALL:
							if (prefix)
								next_pd = insn_exec_pkg::PD_ALL; // RULE_09
						insn_exec_pkg::OP_ROT:
						begin
							next_a  = {cy, a[3:1]}; // RULE_10
							next_cy = a[0];
						end
						insn_exec_pkg::OP_CY_CLR: next_cy = 1'b0; // RULE_17
						insn_exec_pkg::OP_CY_SET: next_cy = 1'b1; // RULE_17
						insn_exec_pkg::OP_PC_CLR: next_c = 1'b0; // RULE_17
						insn_exec_pkg::OP_PC_SET: next_c = 1'b1; // RULE_17
						insn_exec_pkg::OP_PD_CLR:
							if (y <= insn_exec_pkg::PORTD_MAX)
								next_d[y[2:0]] = 1'b0; // RULE_12
						insn_exec_pkg::OP_PD_SET:
							if (y <= insn_exec_pkg::PORTD_MAX)
								next_d[y[2:0]] = 1'b1; // RULE_12
						insn_exec_pkg::OP_SEA1: next_sea_wait = 1'b1; // RULE_14
						insn_exec_pkg::OP_SKIP_ACC_EQ_MEM:
							if (a == mem_dp)
								next_skip = 1'b1; // RULE_15
						insn_exec_pkg::OP_RT, insn_exec_pkg::OP_RTS:
						begin
							stk.pop   = 1'b1; // RULE_16
							next_pc   = top[insn_exec_pkg::ENTRY_W-1 -: PC_W];
							next_skip = (insn == insn_exec_pkg::OP_RTS);
							next_st   = insn_exec_pkg::ST_EXEC2;
						end
						insn_exec_pkg::OP_RTI:
						begin
							stk.pop = 1'b1; // RULE_13
							next_pc = top[insn_exec_pkg::ENTRY_W-1 -: PC_W];
							{next_x, next_y, next_z, next_cy, next_skip, next_chain,
								next_a, next_b} = top[insn_exec_pkg::CTX_W-1:0];
						end
						default: ; // unknown words act as no-operation
					endcase
				end
			end
			insn_exec_pkg::ST_EXEC2: next_st = insn_exec_pkg::ST_IDLE; // RULE_16
		endcase
		// bus waits while an instruction runs, so no access races it
		next_ready = (next_st == insn_exec_pkg::ST_IDLE);
	end

	// registers only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= insn_exec_pkg::ST_IDLE;
			a <= '0;   b <= '0;   x <= '0;   y <= '0;   z <= '0;
			cy <= 1'b0;   skip <= 1'b0;   chain <= 1'b0;
			sea_wait <= 1'b0;   swallow <= 1'b0;   prefix <= 1'b0;
			pc <= '0;   insn <= '0;
			for (int i = 0; i < RAM_N; i++)
				ram[i] <= '0;
			port0 <= '0;   port1 <= '0;   port2 <= '0;   port3 <= '0;
			key_port <= 1'b0;   port_c <= 1'b0;   port_d <= '0;
			powerdown <= insn_exec_pkg::PD_RUN;
			hrdata <= '0;   hreadyout <= 1'b1;   hresp <= insn_exec_pkg::HRESP_OKAY;
			addr_q <= '0;   wr_q <= 1'b0;
		end
		else
		begin
			st <= next_st;
			a <= next_a;   b <= next_b;   x <= next_x;   y <= next_y;   z <= next_z;
			cy <= next_cy;   skip <= next_skip;   chain <= next_chain;
			sea_wait <= next_sea_wait;   swallow <= next_swallow;   prefix <= next_prefix;
			pc <= next_pc;   insn <= next_insn;   ram <= next_ram;
			port0 <= next_p0;   port1 <= next_p1;   port2 <= next_p2;   port3 <= next_p3;
			key_port <= next_k;   port_c <= next_c;   port_d <= next_d;
			powerdown <= next_pd;
			hrdata <= next_hrdata;   hreadyout <= next_ready;   hresp <= next_hresp;
			addr_q <= next_addr_q;   wr_q <= next_wr_q;
		end
	end

	// checks
	property p_lz;
		@(posedge hclk) disable iff (!hresetn)
		live && insn[9:2] == insn_exec_pkg::OP_LZ[9:2] |=> z == $past(insn[1:0]);
	endproperty
	a_lz: assert property (p_lz) else $error("bank pointer not loaded"); // RULE_01

	property p_nop;
		@(posedge hclk) disable iff (!hresetn)
		live && insn == insn_exec_pkg::OP_NOP |=> pc == $past(pc) + 1'b1 && $stable(a)
			&& $stable(cy) && $stable(port0) && $stable(port_d);
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation changed state"); // RULE_02

	property p_port0;
		@(posedge hclk) disable iff (!hresetn)
		live && insn == insn_exec_pkg::OP_P0 |=> port0 == $past(a);
	endproperty
	a_port0: assert property (p_port0) else $error("port 0 latch wrong"); // RULE_04

	property p_or;
		@(posedge hclk) disable iff (!hresetn)
		live && insn == insn_exec_pkg::OP_OR |=> a == ($past(a) | $past(mem_dp)) && $stable(cy);
	endproperty
	a_or: assert property (p_or) else $error("or result wrong"); // RULE_07

	property p_pd_noprefix;
		@(posedge hclk) disable iff (!hresetn)
		live && !prefix && (insn == insn_exec_pkg::OP_PD_DET || insn == insn_exec_pkg::OP_PD_ALL)
			|=> powerdown == insn_exec_pkg::PD_RUN;
	endproperty
	a_pd_noprefix: assert property (p_pd_noprefix) else $error("powerdown without prefix"); // RULE_08

	property p_rot;
		@(posedge hclk) disable iff (!hresetn)
		live && insn == insn_exec_pkg::OP_ROT |=> cy == $past(a[0])
			&& a == {$past(cy), $past(a[3:1])};
	endproperty
	a_rot: assert property (p_rot) else $error("rotate wrong"); // RULE_10

	property p_portd_range;
		@(posedge hclk) disable iff (!hresetn)
		live && y > insn_exec_pkg::PORTD_MAX
			&& (insn == insn_exec_pkg::OP_PD_SET || insn == insn_exec_pkg::OP_PD_CLR)
			|=> $stable(port_d);
	endproperty
	a_portd_range: assert property (p_portd_range) else $error("port d changed"); // RULE_12

	property p_sea;
		@(posedge hclk) disable iff (!hresetn)
		st == insn_exec_pkg::ST_EXEC && powerdown == insn_exec_pkg::PD_RUN && sea_wait
			&& !swallow && a == insn[3:0] |=> skip;
	endproperty
	a_sea: assert property (p_sea) else $error("compare did not skip"); // RULE_14

	property p_ret_two;
		@(posedge hclk) disable iff (!hresetn)
		live && (insn == insn_exec_pkg::OP_RT || insn == insn_exec_pkg::OP_RTS)
			|-> !hreadyout ##1 !hreadyout ##1 hreadyout;
	endproperty
	a_ret_two: assert property (p_ret_two) else $error("return not two cycles"); // RULE_16
endmodule : insn_exec
`default_nettype wire

// >>> core/insn_exec_pkg.sv
// constants, opcodes and register map of the instruction execution block
`default_nettype none
package insn_exec_pkg;
	localparam int PC_W    = 10;
	localparam int CTX_W   = 21;
	localparam int ENTRY_W = PC_W + CTX_W;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W    = 3;
	localparam int RAM_AW  = 4;

	// register byte offsets and register bit positions
	localparam logic [7:0] REG_INSN = 8'h00;
	localparam logic [7:0] REG_ACC  = 8'h04;
	localparam logic [7:0] REG_PTR  = 8'h08;
	localparam logic [7:0] REG_PORT = 8'h0C;
	localparam logic [7:0] REG_PCSP = 8'h10;
	localparam logic [7:0] REG_MEM  = 8'h14;
	localparam logic [7:0] REG_CALL = 8'h18;
	localparam int IRQ_BIT   = 16;
	localparam int CHAIN_BIT = 19;

	// opcodes, 10-bit words
	localparam logic [9:0] OP_NOP      = 10'h000;
	localparam logic [9:0] OP_PD_DET   = 10'h002;
	localparam logic [9:0] OP_PD_ALL   = 10'h008;
	localparam logic [9:0] OP_PD_EN    = 10'h05B;
	localparam logic [9:0] OP_CY_CLR   = 10'h006;
	localparam logic [9:0] OP_CY_SET   = 10'h007;
	localparam logic [9:0] OP_PD_CLR   = 10'h014;
	localparam logic [9:0] OP_PD_SET   = 10'h015;
	localparam logic [9:0] OP_OR       = 10'h019;
	localparam logic [9:0] OP_ROT      = 10'h01D;
	localparam logic [9:0] OP_SEA1     = 10'h025;
	localparam logic [9:0] OP_SEA2     = 10'h070;
	localparam logic [9:0] OP_SKIP_ACC_EQ_MEM     = 10'h026;
	localparam logic [9:0] OP_RT       = 10'h044;
	localparam logic [9:0] OP_RTS      = 10'h045;
	localparam logic [9:0] OP_RTI      = 10'h046;
	localparam logic [9:0] OP_LZ       = 10'h048;
	localparam logic [9:0] OP_MB_CLR   = 10'h04C;
	localparam logic [9:0] OP_MB_SET   = 10'h05C;
	localparam logic [9:0] OP_KEY      = 10'h21F;
	localparam logic [9:0] OP_P0       = 10'h220;
	localparam logic [9:0] OP_P1       = 10'h221;
	localparam logic [9:0] OP_P2       = 10'h222;
	localparam logic [9:0] OP_P3       = 10'h223;
	localparam logic [9:0] OP_PC_CLR   = 10'h28C;
	localparam logic [9:0] OP_PC_SET   = 10'h28D;

	localparam logic [3:0] PORTD_MAX = 4'h5;
	localparam logic [1:0] PD_RUN = 2'h0;
	localparam logic [1:0] PD_DET = 2'h1;
	localparam logic [1:0] PD_ALL = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_EXEC2 = 3'b100
	} exec_state_t;
endpackage : insn_exec_pkg
`default_nettype wire

// >>> core/return_stack.sv
// return stack of flip-flops indexed by the stack pointer
`default_nettype none
module return_stack #(
	parameter int W     = 31,
	parameter int DEPTH = 8,
	parameter int SPW   = 3
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// stack port
	stack_if.store    s
);
	logic [W-1:0]   mem      [DEPTH];
	logic [W-1:0]   next_mem [DEPTH];
	logic [SPW-1:0] sp;
	logic [SPW-1:0] next_sp;

	// stack pointer names the top entry; push pre-increments
	always_comb
	begin
		next_mem = mem;
		next_sp  = sp;
		if (s.push)
		begin
			next_sp = sp + 1'b1;
			next_mem[next_sp] = s.wdata;
		end
		else if (s.pop)
			next_sp = sp - 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sp <= '1;
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		end
		else
		begin
			sp  <= next_sp;
			mem <= next_mem;
		end
	end

	assign s.rdata = mem[sp];
	assign s.sp    = sp;
endmodule : return_stack
`default_nettype wire

// >>> core/stack_if.sv
// link between the executor and its return stack
`default_nettype none
interface stack_if #(
	parameter int W   = 31,
	parameter int SPW = 3
);
	logic           push;
	logic           pop;
	logic [W-1:0]   wdata;
	logic [W-1:0]   rdata;
	logic [SPW-1:0] sp;
	modport ctrl  (output push, output pop, output wdata, input rdata, input sp);
	modport store (input push, input pop, input wdata, output rdata, output sp);
endinterface : stack_if
`default_nettype wire

// >>> core/unused_placeholder_none.sv
// intentionally empty file holder
`default_nettype none
`default_nettype wire
